// File: rtl/usbdc_top.sv
// Channel configuration, teardown and emulation control of the USB packet DMA, APB slave.
// Operation
// - Two-bit teardown queue manager selector.
// - Twelve-bit teardown queue number selects queue.
// - Four transmit channels, two registers each.
// - Transmit return queue manager and number.
// - Transmit enable bit cleared after teardown.
// - Transmit teardown request bit stays set.
// - Four receive channels, two registers each.
// - Descriptor kind field, host is one.
// - Receive destination queue manager and number.
// - Receive enable bit cleared after teardown.
// - Receive teardown bit set on completion.
// - Error mode zero: drop and reclaim.
// - Error mode one: idle, retry later.
// - Eight-bit skip in first buffer.
// - Read-only revision split over two halves.
// - Soft-stop and free-run emulation bits.
module usbdc_top #(
  parameter logic [15:0] REV_LOW_HALF = 16'h0001,
  parameter logic [15:0] REV_HIGH_HALF = 16'h0002
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:0] TX_TD_DONE_IN,
  input wire logic [3:0] RX_TD_DONE_IN,
  input wire logic [3:0] RX_STARVE_IN,
  input wire logic EMU_SUSPEND_IN,
  input wire logic PKT_BOUNDARY_IN,
  output logic [1:0] TD_QMGR_OUT,
  output logic [11:0] TD_QNUM_OUT,
  output logic [3:0] TX_ENABLE_OUT,
  output logic [3:0] TX_TEARDOWN_OUT,
  output logic [7:0] TX_RET_QMGR_OUT,
  output logic [47:0] TX_RET_QNUM_OUT,
  output logic [3:0] RX_ENABLE_OUT,
  output logic [7:0] RX_KIND_OUT,
  output logic [7:0] RX_QMGR_OUT,
  output logic [47:0] RX_QNUM_OUT,
  output logic [31:0] RX_SKIP_OUT,
  output logic [3:0] RX_STARVE_DROP_OUT,
  output logic [3:0] RX_STARVE_RETRY_OUT,
  output logic DMA_HALT_OUT,
  output logic IRQ_OUT
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] td_qmgr;
    logic [11:0] td_qnum;
    logic emu_soft;
    logic emu_free;
    logic [3:0][1:0] tx_qmgr;
    logic [3:0][11:0] tx_qnum;
    logic [3:0] tx_en;
    logic [3:0] tx_td;
    logic [3:0][1:0] rx_kind;
    logic [3:0][1:0] rx_qmgr;
    logic [3:0][11:0] rx_qnum;
    logic [3:0] rx_en;
    logic [3:0] rx_td;
    logic [3:0] rx_err;
    logic [3:0][7:0] rx_skip;
    logic [11:0] irq_stat;
    logic [11:0] irq_mask;
    logic irq;
    logic [3:0] drop;
    logic [3:0] retry;
    usbdc_pkg::usbdc_emu_t emu;
    logic halt;
    logic sus_meta;
    logic sus_sync;
  } usbdc_state_t;

  usbdc_state_t state_q;
  usbdc_state_t state_d;

  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic wr;
    logic take;
    logic [15:0] wd;
    logic [7:0] a;
    logic [7:0] ch_off;
    rd = 32'h0000_0000;
    hit = 1'b0;
    wd = PWDATA_IN[15:0];
    a = PADDR_IN;
    ch_off = 8'h00;
    // The access phase is held one cycle: pready rises on its first edge and the
    // write lands on the edge that samples it, so read data never needs a comb path.
    take = PSEL_IN & PENABLE_IN & ~state_q.pready;
    wr = PSEL_IN & PENABLE_IN & state_q.pready & PWRITE_IN & ~state_q.pslverr;
    state_d = state_q;
    state_d.drop = 4'h0;
    state_d.retry = 4'h0;

    // Address decode and read mux.
    case (a)
      usbdc_pkg::OFF_REV_LOW: begin
        rd = {16'h0000, REV_LOW_HALF};
        hit = 1'b1;
      end
      usbdc_pkg::OFF_REV_HIGH: begin
        rd = {16'h0000, REV_HIGH_HALF};
        hit = 1'b1;
      end
      usbdc_pkg::OFF_TD_QSEL: begin
        rd = {18'h00000, state_q.td_qmgr, state_q.td_qnum};
        hit = 1'b1;
      end
      usbdc_pkg::OFF_EMU: begin
        rd = {30'h0000_0000, state_q.emu_soft, state_q.emu_free};
        hit = 1'b1;
      end
      usbdc_pkg::OFF_IRQ_STAT: begin
        rd = {20'h00000, state_q.irq_stat};
        hit = 1'b1;
      end
      usbdc_pkg::OFF_IRQ_MASK: begin
        rd = {20'h00000, state_q.irq_mask};
        hit = 1'b1;
      end
      default: begin
        rd = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < usbdc_pkg::N_CH; i++) begin
      ch_off = 8'(usbdc_pkg::CH_STRIDE * i);
      if (a == usbdc_pkg::OFF_TX_QUEUE + ch_off) begin
        rd = {18'h00000, state_q.tx_qmgr[i], state_q.tx_qnum[i]};
        hit = 1'b1;
      end
      if (a == usbdc_pkg::OFF_TX_CTRL + ch_off) begin
        rd = {16'h0000, state_q.tx_en[i], state_q.tx_td[i], 14'h0000};
        hit = 1'b1;
      end
      if (a == usbdc_pkg::OFF_RX_QUEUE + ch_off) begin
        rd = {16'h0000, state_q.rx_kind[i], state_q.rx_qmgr[i], state_q.rx_qnum[i]};
        hit = 1'b1;
      end
      if (a == usbdc_pkg::OFF_RX_CTRL + ch_off) begin
        rd = {16'h0000, state_q.rx_en[i], state_q.rx_td[i], 5'h00, state_q.rx_err[i],
              state_q.rx_skip[i]};
        hit = 1'b1;
      end
    end

    state_d.pready = take;
    if (take) begin
      state_d.pslverr = ~hit;
      state_d.prdata = (hit & ~PWRITE_IN) ? rd : 32'h0000_0000;
    end

    // Software writes.
    if (wr) begin
      if (a == usbdc_pkg::OFF_TD_QSEL) begin
        state_d.td_qmgr = wd[usbdc_pkg::QMGR_LSB +: usbdc_pkg::QMGR_W];
        state_d.td_qnum = wd[usbdc_pkg::QNUM_LSB +: usbdc_pkg::QNUM_W];
      end
      if (a == usbdc_pkg::OFF_EMU) begin
        state_d.emu_soft = wd[usbdc_pkg::EMU_SOFT_BIT];
        state_d.emu_free = wd[usbdc_pkg::EMU_FREE_BIT];
      end
      if (a == usbdc_pkg::OFF_IRQ_STAT) begin
        state_d.irq_stat = state_q.irq_stat & ~wd[11:0];
      end
      if (a == usbdc_pkg::OFF_IRQ_MASK) begin
        state_d.irq_mask = wd[11:0];
      end
      for (int i = 0; i < usbdc_pkg::N_CH; i++) begin
        ch_off = 8'(usbdc_pkg::CH_STRIDE * i);
        if (a == usbdc_pkg::OFF_TX_QUEUE + ch_off) begin
          state_d.tx_qmgr[i] = wd[usbdc_pkg::QMGR_LSB +: usbdc_pkg::QMGR_W];
          state_d.tx_qnum[i] = wd[usbdc_pkg::QNUM_LSB +: usbdc_pkg::QNUM_W];
        end
        if (a == usbdc_pkg::OFF_TX_CTRL + ch_off) begin
          state_d.tx_en[i] = wd[usbdc_pkg::EN_BIT];
          state_d.tx_td[i] = wd[usbdc_pkg::TD_BIT];
        end
        if (a == usbdc_pkg::OFF_RX_QUEUE + ch_off) begin
          state_d.rx_kind[i] = wd[usbdc_pkg::KIND_LSB +: usbdc_pkg::KIND_W];
          state_d.rx_qmgr[i] = wd[usbdc_pkg::QMGR_LSB +: usbdc_pkg::QMGR_W];
          state_d.rx_qnum[i] = wd[usbdc_pkg::QNUM_LSB +: usbdc_pkg::QNUM_W];
        end
        if (a == usbdc_pkg::OFF_RX_CTRL + ch_off) begin
          state_d.rx_en[i] = wd[usbdc_pkg::EN_BIT];
          state_d.rx_td[i] = wd[usbdc_pkg::TD_BIT];
          state_d.rx_err[i] = wd[usbdc_pkg::ERR_BIT];
          state_d.rx_skip[i] = wd[usbdc_pkg::SKIP_LSB +: usbdc_pkg::SKIP_W];
        end
      end
    end

    // Engine events come after software so that completion wins a same-cycle write.
    for (int i = 0; i < usbdc_pkg::N_CH; i++) begin
      if (TX_TD_DONE_IN[i]) begin
        state_d.tx_en[i] = 1'b0;
        state_d.irq_stat[usbdc_pkg::IRQ_TX_TD_LSB + i] = 1'b1;
      end
      if (RX_TD_DONE_IN[i]) begin
        state_d.rx_en[i] = 1'b0;
        state_d.rx_td[i] = 1'b1;
        state_d.irq_stat[usbdc_pkg::IRQ_RX_TD_LSB + i] = 1'b1;
      end
      // Starvation only matters on a live channel; the mode bit picks the recovery.
      if (RX_STARVE_IN[i] && state_q.rx_en[i]) begin
        state_d.drop[i] = ~state_q.rx_err[i];
        state_d.retry[i] = state_q.rx_err[i];
        state_d.irq_stat[usbdc_pkg::IRQ_STARVE_LSB + i] = 1'b1;
      end
    end
    state_d.irq = |(state_d.irq_stat & state_d.irq_mask);

    // Emulation suspend: the pin passes two flops before the state machine reads it.
    state_d.sus_meta = EMU_SUSPEND_IN;
    state_d.sus_sync = state_q.sus_meta;
    case (state_q.emu)
      usbdc_pkg::USBDC_RUN: begin
        if (state_q.sus_sync && !state_q.emu_free) begin
          state_d.emu = state_q.emu_soft ? usbdc_pkg::USBDC_DRAIN : usbdc_pkg::USBDC_HALT;
        end
      end
      usbdc_pkg::USBDC_DRAIN: begin
        if (!state_q.sus_sync || state_q.emu_free) begin
          state_d.emu = usbdc_pkg::USBDC_RUN;
        // Clearing soft-stop while draining falls back to the immediate halt.
        end else if (PKT_BOUNDARY_IN || !state_q.emu_soft) begin
          state_d.emu = usbdc_pkg::USBDC_HALT;
        end
      end
      usbdc_pkg::USBDC_HALT: begin
        if (!state_q.sus_sync || state_q.emu_free) begin
          state_d.emu = usbdc_pkg::USBDC_RUN;
        end
      end
      default: begin
        state_d.emu = usbdc_pkg::USBDC_RUN;
      end
    endcase
    // Free-run overrides at once even mid-drain, so a debugger never freezes it.
    if (state_q.emu_free) begin
      state_d.emu = usbdc_pkg::USBDC_RUN;
    end
    state_d.halt = (state_d.emu == usbdc_pkg::USBDC_HALT);
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= '0;
      state_q.irq_mask <= usbdc_pkg::IRQ_MASK_RESET;
      state_q.rx_kind <= {usbdc_pkg::N_CH{usbdc_pkg::KIND_RESET}};
      state_q.emu <= usbdc_pkg::USBDC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign PRDATA_OUT = state_q.prdata;
  assign PREADY_OUT = state_q.pready;
  assign PSLVERR_OUT = state_q.pslverr;
  assign TD_QMGR_OUT = state_q.td_qmgr;
  assign TD_QNUM_OUT = state_q.td_qnum;
  assign TX_ENABLE_OUT = state_q.tx_en;
  assign TX_TEARDOWN_OUT = state_q.tx_td;
  assign TX_RET_QMGR_OUT = state_q.tx_qmgr;
  assign TX_RET_QNUM_OUT = state_q.tx_qnum;
  assign RX_ENABLE_OUT = state_q.rx_en;
  assign RX_KIND_OUT = state_q.rx_kind;
  assign RX_QMGR_OUT = state_q.rx_qmgr;
  assign RX_QNUM_OUT = state_q.rx_qnum;
  assign RX_SKIP_OUT = state_q.rx_skip;
  assign RX_STARVE_DROP_OUT = state_q.drop;
  assign RX_STARVE_RETRY_OUT = state_q.retry;
  assign DMA_HALT_OUT = state_q.halt;
  assign IRQ_OUT = state_q.irq;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  ready_one_cycle_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("pready held longer than one cycle");

  tx_enable_clear_a: assert property (
    |TX_TD_DONE_IN |=> ((TX_ENABLE_OUT & $past(TX_TD_DONE_IN)) == 4'h0))
    else $error("tx enable not cleared after teardown");

  tx_teardown_hold_a: assert property (
    |(TX_TEARDOWN_OUT & TX_TD_DONE_IN) |=>
      ((TX_TEARDOWN_OUT & $past(TX_TEARDOWN_OUT & TX_TD_DONE_IN))
       == $past(TX_TEARDOWN_OUT & TX_TD_DONE_IN)))
    else $error("tx teardown bit lost at completion");

  rx_enable_clear_a: assert property (
    |RX_TD_DONE_IN |=> ((RX_ENABLE_OUT & $past(RX_TD_DONE_IN)) == 4'h0))
    else $error("rx enable not cleared after teardown");

  rx_teardown_set_a: assert property (
    |RX_TD_DONE_IN |=> ((state_q.rx_td & $past(RX_TD_DONE_IN)) == $past(RX_TD_DONE_IN)))
    else $error("rx teardown bit not set at completion");

  starve_drop_a: assert property (
    |RX_STARVE_IN |=> (RX_STARVE_DROP_OUT == $past(RX_STARVE_IN & RX_ENABLE_OUT & ~state_q.rx_err)))
    else $error("starvation drop pulse wrong");

  starve_retry_a: assert property (
    |RX_STARVE_IN |=> (RX_STARVE_RETRY_OUT == $past(RX_STARVE_IN & RX_ENABLE_OUT & state_q.rx_err))
      ##1 (RX_STARVE_RETRY_OUT == 4'h0 || $past(|RX_STARVE_IN)))
    else $error("starvation retry pulse wrong");

  free_run_a: assert property (state_q.emu_free |=> !DMA_HALT_OUT)
    else $error("halted while free-run set");

  hard_stop_a: assert property (
    state_q.sus_sync && !state_q.emu_free && !state_q.emu_soft && !DMA_HALT_OUT
      |=> DMA_HALT_OUT)
    else $error("immediate halt missing");

  irq_level_a: assert property (
    |((TX_TD_DONE_IN & state_q.irq_mask[usbdc_pkg::IRQ_TX_TD_LSB +: 4])
      | (RX_TD_DONE_IN & state_q.irq_mask[usbdc_pkg::IRQ_RX_TD_LSB +: 4]))
      && !(PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN) |=> IRQ_OUT)
    else $error("interrupt not raised by unmasked event");

  rev_read_a: assert property (
    PSEL_IN && PENABLE_IN && !PWRITE_IN && !PREADY_OUT && PADDR_IN == usbdc_pkg::OFF_REV_HIGH
      |=> PREADY_OUT && PRDATA_OUT == {16'h0000, REV_HIGH_HALF})
    else $error("revision high half read wrong");

endmodule // usbdc_top

// File: rtl/usbdc_pkg.sv
// Shared constants and types for the USB packet DMA channel configuration block.
package usbdc_pkg;

  localparam int N_CH = 4;

  // Byte offsets on the APB register bus.
  localparam logic [7:0] OFF_REV_LOW = 8'h00;
  localparam logic [7:0] OFF_REV_HIGH = 8'h04;
  localparam logic [7:0] OFF_TD_QSEL = 8'h08;
  localparam logic [7:0] OFF_EMU = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_TX_QUEUE = 8'h20;
  localparam logic [7:0] OFF_TX_CTRL = 8'h24;
  localparam logic [7:0] OFF_RX_QUEUE = 8'h40;
  localparam logic [7:0] OFF_RX_CTRL = 8'h44;
  localparam logic [7:0] CH_STRIDE = 8'h08;

  // Field positions inside the 16-bit registers.
  localparam int QNUM_LSB = 0;
  localparam int QNUM_W = 12;
  localparam int QMGR_LSB = 12;
  localparam int QMGR_W = 2;
  localparam int KIND_LSB = 14;
  localparam int KIND_W = 2;
  localparam int EN_BIT = 15;
  localparam int TD_BIT = 14;
  localparam int ERR_BIT = 8;
  localparam int SKIP_LSB = 0;
  localparam int SKIP_W = 8;
  localparam int EMU_SOFT_BIT = 1;
  localparam int EMU_FREE_BIT = 0;

  // Interrupt status layout: transmit teardown, receive teardown, receive starvation.
  localparam int IRQ_W = 12;
  localparam int IRQ_TX_TD_LSB = 0;
  localparam int IRQ_RX_TD_LSB = 4;
  localparam int IRQ_STARVE_LSB = 8;

  // Host kind code and reset values.
  localparam logic [KIND_W-1:0] KIND_HOST = 2'h1;
  localparam logic [KIND_W-1:0] KIND_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 12'h000;

  typedef enum logic [1:0] {
    USBDC_RUN = 2'b00,
    USBDC_DRAIN = 2'b01,
    USBDC_HALT = 2'b10
  } usbdc_emu_t;

endpackage

// File: test/usbdc_far_model.sv
// Far-side engine model: teardown completions, starvation and packet boundaries.
module usbdc_far_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] dly_in,
  input wire logic [3:0] tx_en_in,
  input wire logic [3:0] tx_td_in,
  input wire logic [3:0] rx_td_in,
  input wire logic [3:0] starve_in,
  input wire logic bnd_in,
  output logic [3:0] tx_done_out,
  output logic [3:0] rx_done_out,
  output logic [3:0] starve_out,
  output logic bnd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sent;
  logic [3:0] cnt [4];
  // One transmit completion per teardown request, after a delay the bench picks, so slow answers are seen; receive completions follow rx_td_in one cycle later.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {tx_done_out, rx_done_out, starve_out, bnd_out, sent} <= '0;
      cnt <= '{default: 4'h0};
    end else begin
      rx_done_out <= rx_td_in;
      starve_out <= starve_in;
      bnd_out <= bnd_in;
      for (int i = 0; i < 4; i++) begin
        tx_done_out[i] <= 1'b0;
        cnt[i] <= 4'h0;
        if (!tx_td_in[i]) begin
          sent[i] <= 1'b0;
        end else if (tx_en_in[i] && !sent[i]) begin
          cnt[i] <= cnt[i] + 4'h1;
          if (cnt[i] == dly_in) begin
            tx_done_out[i] <= 1'b1;
            sent[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule // usbdc_far_model

// File: test/usb_dma_channel_config_tb_top.sv
// Self-checking bench for the USB packet DMA channel configuration block.
module usb_dma_channel_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] REVL = 16'h2a71; // Arbitrary value.
  localparam logic [15:0] REVH = 16'h0c4e; // Arbitrary value.
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, susp = 1'b0, bc = 1'b0;
  logic err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] rxc = 4'h0, stc = 4'h0, dly = 4'h0, e;
  logic [13:0] v, w;
  logic [7:0] sk [4];
  wire [31:0] prdata, rx_skip;
  wire pready, pslverr, halt, irq, bnd;
  wire [1:0] td_qmgr;
  wire [11:0] td_qnum;
  wire [3:0] tx_en, tx_td, rx_en, drop, retry, txd, rxd, stv;
  wire [7:0] tx_rqm, rx_kind, rx_qm;
  wire [47:0] tx_rqn, rx_qn;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int drops = 0;
  int retries = 0;

  usbdc_top #(.REV_LOW_HALF(REVL), .REV_HIGH_HALF(REVH)) dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TX_TD_DONE_IN(txd), .RX_TD_DONE_IN(rxd), .RX_STARVE_IN(stv),
    .EMU_SUSPEND_IN(susp), .PKT_BOUNDARY_IN(bnd), .TD_QMGR_OUT(td_qmgr), .TD_QNUM_OUT(td_qnum),
    .TX_ENABLE_OUT(tx_en), .TX_TEARDOWN_OUT(tx_td), .TX_RET_QMGR_OUT(tx_rqm),
    .TX_RET_QNUM_OUT(tx_rqn), .RX_ENABLE_OUT(rx_en), .RX_KIND_OUT(rx_kind), .RX_QMGR_OUT(rx_qm),
    .RX_QNUM_OUT(rx_qn), .RX_SKIP_OUT(rx_skip), .RX_STARVE_DROP_OUT(drop),
    .RX_STARVE_RETRY_OUT(retry), .DMA_HALT_OUT(halt), .IRQ_OUT(irq));

  usbdc_far_model far (
    .clk_in(clk), .rst_n_in(rst_n), .dly_in(dly), .tx_en_in(tx_en), .tx_td_in(tx_td),
    .rx_td_in(rxc), .starve_in(stc), .bnd_in(bc), .tx_done_out(txd), .rx_done_out(rxd),
    .starve_out(stv), .bnd_out(bnd));

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The request is held until the edge that samples ready high; data is taken for that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // Read at the edge, before the slave's flops update, so we see what it samples there.
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  function automatic logic [7:0] ca(input logic [7:0] b, input int i);
    return b + usbdc_pkg::CH_STRIDE * 8'(i);
  endfunction

  task automatic pulse(input logic [3:0] s, input logic b);
    @(posedge clk);
    stc <= s;
    bc <= b;
    @(posedge clk);
    stc <= 4'h0;
    bc <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    drops += $countones(drop);
    retries += $countones(retry);
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    int k;
    k = $urandom(53253);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1, usbdc_pkg::OFF_REV_HIGH, 16'hffff);
    apb(0, usbdc_pkg::OFF_REV_HIGH, 16'h0);
    chk(rd, REVH);
    apb(0, usbdc_pkg::OFF_REV_LOW, 16'h0);
    chk(rd, REVL);
    apb(0, 8'h1c, 16'h0);
    chk({err, rd}, 33'h1_0000_0000);
    apb(0, usbdc_pkg::OFF_TD_QSEL, 16'h0);
    chk(rd, 32'h0);
    v = 14'($urandom);
    apb(1, usbdc_pkg::OFF_TD_QSEL, {2'b11, v});
    apb(0, usbdc_pkg::OFF_TD_QSEL, 16'h0);
    chk({rd, td_qmgr, td_qnum}, {18'h0, v, v});
    for (int i = 0; i < 4; i++) begin
      v = 14'($urandom);
      w = 14'($urandom);
      e[i] = 1'($urandom);
      sk[i] = (i == 0) ? 8'hff : 8'($urandom);
      apb(1, ca(usbdc_pkg::OFF_TX_QUEUE, i), {2'b00, v});
      apb(1, ca(usbdc_pkg::OFF_RX_QUEUE, i), {2'(i), w});
      apb(1, ca(usbdc_pkg::OFF_RX_CTRL, i), {1'b1, 6'h0, e[i], sk[i]});
      repeat (2) @(negedge clk);
      chk({tx_rqm[2*i+:2], tx_rqn[12*i+:12]}, v);
      chk({rx_kind[2*i+:2], rx_qm[2*i+:2], rx_qn[12*i+:12]}, {2'(i), w});
      chk({rx_en[i], rx_skip[8*i+:8]}, {1'b1, sk[i]});
    end
    pulse(4'hf, 1'b0);
    chk(drops, 4 - $countones(e));
    chk(retries, $countones(e));
    apb(0, usbdc_pkg::OFF_IRQ_STAT, 16'h0);
    chk({rd, irq}, {32'hf00, 1'b0});
    apb(1, usbdc_pkg::OFF_IRQ_MASK, 16'h0fff);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    apb(1, usbdc_pkg::OFF_IRQ_STAT, 16'h0f00);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dly <= 4'(i * 3);
      apb(1, ca(usbdc_pkg::OFF_TX_CTRL, i), 16'h8000);
      apb(1, ca(usbdc_pkg::OFF_TX_CTRL, i), 16'hc000);
      for (k = 0; k < 30 && tx_en[i] !== 1'b0; k++) @(negedge clk);
      apb(0, ca(usbdc_pkg::OFF_TX_CTRL, i), 16'h0);
      chk({rd, tx_en, tx_td[i]}, {32'h4000, 4'h0, 1'b1});
      @(posedge clk);
      rxc <= 4'h1 << i;
      @(posedge clk);
      rxc <= 4'h0;
      repeat (3) @(negedge clk);
      apb(0, ca(usbdc_pkg::OFF_RX_CTRL, i), 16'h0);
      chk({rd[15:14], rx_en[i]}, 3'b010);
      apb(1, ca(usbdc_pkg::OFF_RX_CTRL, i), {8'h00, sk[i]});
      apb(0, ca(usbdc_pkg::OFF_RX_CTRL, i), 16'h0);
      chk(rd[15:14], 2'b00);
    end
    pulse(4'hf, 1'b0);
    chk(drops + retries, 4);
    apb(0, usbdc_pkg::OFF_IRQ_STAT, 16'h0);
    chk({rd, irq}, {32'h0ff, 1'b1});
    apb(1, usbdc_pkg::OFF_EMU, 16'hffff);
    apb(0, usbdc_pkg::OFF_EMU, 16'h0);
    chk(rd, 32'h3);
    susp <= 1'b1;
    repeat (8) @(negedge clk);
    chk(halt, 1'b0);
    apb(1, usbdc_pkg::OFF_EMU, 16'h0002);
    repeat (6) @(negedge clk);
    chk(halt, 1'b0);
    pulse(4'h0, 1'b1);
    chk(halt, 1'b1);
    apb(1, usbdc_pkg::OFF_EMU, 16'h0000);
    susp <= 1'b0;
    repeat (6) @(negedge clk);
    chk(halt, 1'b0);
    @(posedge clk);
    susp <= 1'b1;
    repeat (6) @(negedge clk);
    chk(halt, 1'b1);
    end_sim();
  end
endmodule // usb_dma_channel_config_tb_top
